/* logic/smc_map.vh */
// Register map, field positions and reset values of the modulator control block.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef SMC_MAP_VH
`define SMC_MAP_VH

// Register offsets on the plain register port
`define SMC_ADDR_W 4
`define SMC_OFS_CONTROL 4'h0
`define SMC_OFS_SOURCE 4'h1

// Control register fields
`define SMC_CTL_ENABLE 7
`define SMC_CTL_POLARITY 4
`define SMC_CTL_STATUS 3
`define SMC_CTL_SWBIT 0

// Source select register fields
`define SMC_SRC_MODSEL 0
`define SMC_SRC_HISEL 4
`define SMC_SRC_LOSEL 6

// Reset values
`define SMC_CONTROL_RST 8'h00
`define SMC_SOURCE_RST 8'h00

// Writable masks, everything else reads zero except control status bit 3
`define SMC_CONTROL_WMASK 8'h91
`define SMC_SOURCE_WMASK 8'h51

`endif

/* logic/smc_sync.v */
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/1ns
`default_nettype none

module smc_sync #(
   parameter W = 3
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // First stage feeds only the second stage
   always @(posedge core_clk) begin
      if (rst) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

`default_nettype wire

/* logic/smc_top.v */
// Control and status logic of the data signal modulator, with its mixing stage.
// Assumes a single 100 MHz core_clk, synchronous reset, and a register master
// that never issues read and write strobes in the same cycle.
// Carrier and source pins have no timing relation to core_clk; they are
// resynchronised, so a pin change reaches the output three clocks later.
`timescale 1ns/1ns
`default_nettype none
`include "smc_map.vh"

// Summary of operation
// - Enable set: mix selected inputs onto output
// - Enable clear: no modulated output
// - Control bits 6-5, 2-1 read zero
// - Polarity set: inverted output, idles high
// - Polarity clear: true output, idles low
// - Status bit 3 reads sampled output level
// - Software bit 0 usable as modulation source
// - Sampled status lags the output by one clock
module smc_top (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Register port
   input wire [`SMC_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Modulation inputs from pins
   input wire ext_source,
   input wire carrier_a,
   input wire carrier_b,
   // Modulated output pin
   output reg mod_out
);

   // Register storage
   reg [7:0] control_ff;
   reg [7:0] source_ff;
   // Next-state values
   reg [7:0] nxt_control;
   reg [7:0] nxt_source;
   reg [7:0] nxt_rdata;
   // Output path
   reg raw_mix;
   reg nxt_mod_out;
   reg status_ff;
   // Synchronised pins
   wire [2:0] pins_sync;
   wire ext_source_s;
   wire carrier_a_s;
   wire carrier_b_s;
   // Decoded fields
   wire enable;
   wire polarity;
   wire sw_bit;
   wire use_ext;
   wire hi_sel;
   wire lo_sel;
   wire mod_src;
   wire carrier_hi;
   wire carrier_lo;

   // Masks write data so only implemented fields can store
   // Keeping old bits outside the mask makes unused writes harmless
   function [7:0] smc_masked;
      input [7:0] old_val;
      input [7:0] new_val;
      input [7:0] mask;
      begin
         smc_masked = (new_val & mask) | (old_val & ~mask);
      end
   endfunction

   // Selects one of the two carrier pins
   function smc_pick;
      input sel;
      input a;
      input b;
      begin
         smc_pick = sel ? b : a;
      end
   endfunction

   // Pins are asynchronous to core_clk, so they pass two flops first
   smc_sync #(
      .W(3)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({carrier_b, carrier_a, ext_source}),
      .sync_out(pins_sync)
   );

   // Bit order follows the concatenation at the synchroniser input
   assign ext_source_s = pins_sync[0];
   assign carrier_a_s = pins_sync[1];
   assign carrier_b_s = pins_sync[2];

   // Field decode
   assign enable = control_ff[`SMC_CTL_ENABLE];
   assign polarity = control_ff[`SMC_CTL_POLARITY];
   assign sw_bit = control_ff[`SMC_CTL_SWBIT];
   assign use_ext = source_ff[`SMC_SRC_MODSEL];
   assign hi_sel = source_ff[`SMC_SRC_HISEL];
   assign lo_sel = source_ff[`SMC_SRC_LOSEL];

   // Software bit or the external pin drives the modulation data
   assign mod_src = use_ext ? ext_source_s : sw_bit;
   assign carrier_hi = smc_pick(hi_sel, carrier_a_s, carrier_b_s);
   assign carrier_lo = smc_pick(lo_sel, carrier_a_s, carrier_b_s);

   // Register write path; only masked fields take new data
   always @* begin
      nxt_control = control_ff;
      nxt_source = source_ff;
      if (reg_wr) begin
         case (reg_addr)
            `SMC_OFS_CONTROL: begin
               // Status and unused bits are outside the mask
               nxt_control = smc_masked(control_ff, reg_wdata, `SMC_CONTROL_WMASK);
            end
            `SMC_OFS_SOURCE: begin
               // Only the select fields are implemented here
               nxt_source = smc_masked(source_ff, reg_wdata, `SMC_SOURCE_WMASK);
            end
            default: begin
               // Unmapped offsets are ignored
               nxt_control = control_ff;
            end
         endcase
      end
   end

   // Mixing stage: data high picks the high carrier, low the low one
   always @* begin
      if (enable) begin
         raw_mix = mod_src ? carrier_hi : carrier_lo;
      end else begin
         // Disabled module contributes nothing
         raw_mix = 1'b0;
      end
      // Inversion makes the idle level high, else the idle level is low
      if (polarity) begin
         nxt_mod_out = ~raw_mix;
      end else begin
         nxt_mod_out = raw_mix;
      end
   end

   // Read data are valid only in the cycle after the strobe
   always @* begin
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `SMC_OFS_CONTROL: begin
               // Unused positions are forced to zero by the mask
               nxt_rdata = control_ff & `SMC_CONTROL_WMASK;
               nxt_rdata[`SMC_CTL_STATUS] = status_ff;
            end
            `SMC_OFS_SOURCE: begin
               // Source register reads back only its implemented selects
               nxt_rdata = source_ff & `SMC_SOURCE_WMASK;
            end
            default: begin
               // Unmapped offsets read zero
               nxt_rdata = 8'h00;
            end
         endcase
      end
   end

   // Control register; reset leaves the modulator disabled, true polarity
   always @(posedge core_clk) begin
      if (rst) begin
         control_ff <= `SMC_CONTROL_RST;
      end else begin
         control_ff <= nxt_control;
      end
   end

   // Source select register, kept apart so each register stands alone
   always @(posedge core_clk) begin
      if (rst) begin
         source_ff <= `SMC_SOURCE_RST;
      end else begin
         source_ff <= nxt_source;
      end
   end

   // Read data register; falls back to zero when no read strobe was seen
   always @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= nxt_rdata;
      end
   end

   // Output pin flop, so the pin never shows a decode glitch
   always @(posedge core_clk) begin
      if (rst) begin
         mod_out <= 1'b0;
      end else begin
         mod_out <= nxt_mod_out;
      end
   end

   // Status sample of the pin level for software
   always @(posedge core_clk) begin
      if (rst) begin
         status_ff <= 1'b0;
      end else begin
         // Sampled once per clock from the output flop, so it trails mod_out by one cycle
         status_ff <= mod_out;
      end
   end

endmodule

`default_nettype wire

/* testbench/smc_props.sv */
// Port checker of the modulator control block.
// Assumes one clock and a register port that answers reads one cycle later.
`timescale 1ns/1ns
`default_nettype none
module smc_props (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Output pin
   input wire logic mod_out
);
   reg [7:0] ctl_ff;
   // Shadow of writable control bits; ignored bits never land here
   always @(posedge core_clk) begin
      if (rst)
         ctl_ff <= 8'h00;
      else if (reg_wr && reg_addr == 4'h0)
         ctl_ff <= reg_wdata & 8'h91;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Only control reads carry the unused positions; source reads may set bit 6
   property p_rsv; reg_rd && reg_addr == 4'h0 |=>
      reg_rdata[6:5] == 2'h0 && reg_rdata[2:1] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
   property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_ctl; reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 8'h91) == $past(ctl_ff); endproperty
   a_ctl: assert property (p_ctl) else $error("ctl");
   property p_unm; reg_rd && reg_addr > 4'h1 |=> reg_rdata == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unm");
   property p_low; ctl_ff[7:4] == 4'h0 |=> !mod_out; endproperty
   a_low: assert property (p_low) else $error("low");
   property p_high; ctl_ff[7:4] == 4'h1 |=> mod_out; endproperty
   a_high: assert property (p_high) else $error("high");
   property p_off; !ctl_ff[7] && $stable(ctl_ff) |=> $stable(mod_out); endproperty
   a_off: assert property (p_off) else $error("off");
   // A steady output gives one answer whichever cycle status samples it
   property p_st; reg_rd && reg_addr == 4'h0 && $stable(mod_out) &&
      mod_out == $past(mod_out, 2) |=> reg_rdata[3] == $past(mod_out); endproperty
   a_st: assert property (p_st) else $error("st");
   c_rd: cover property (reg_rd && reg_addr == 4'h0);
   c_on: cover property (ctl_ff[7] && mod_out);
   c_inv: cover property (ctl_ff[7:4] == 4'h1);
endmodule
bind smc_top smc_props u_props (.*);
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of the modulator control block.
// Assumes design and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic core_clk, rst, reg_wr, reg_rd, ext_source, carrier_a, carrier_b, e;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, v, c;
   wire [7:0] reg_rdata;
   wire mod_out;
   int n_fail, samples_checked, cyc, i;
   // Carriers are driven so each selection can be told apart
   smc_top dut_u (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .ext_source(ext_source),
      .carrier_a(carrier_a),
      .carrier_b(carrier_b),
      .mod_out(mod_out)
   );
   // Clock at 100 MHz
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report;
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One-cycle strobes launched just after an edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      {rst, reg_wr, reg_rd, ext_source, reg_addr, reg_wdata} = {4'h8, 12'h000};
      {carrier_a, carrier_b} = 2'h2;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rd(4'h0);
      chk("rst", v, 8'h00);
      chk("rst_out", {7'h00, mod_out}, 8'h00);
      // Ignored select bits set; only the implemented ones read back
      wr(4'h1, 8'hee);
      rd(4'h1);
      chk("src", v, 8'h40);
      // All enable, polarity and software bit mixes, ignored bits set
      for (i = 0; i < 8; i++) begin
         c = {i[2], 2'h3, i[1], 1'b1, 2'h3, i[0]};
         e = i[2] ? i[0] ^ i[1] : i[1];
         wr(4'h0, c);
         repeat (6) @(posedge core_clk);
         #1;
         chk("out", {7'h00, mod_out}, {7'h00, e});
         rd(4'h0);
         chk("ctl", v, (c & 8'h91) | {4'h0, e, 3'h0});
      end
      // External pin as source
      wr(4'h1, 8'h41);
      wr(4'h0, 8'h80);
      for (i = 0; i < 4; i++) begin
         @(posedge core_clk);
         ext_source <= i[0];
         repeat (6) @(posedge core_clk);
         #1;
         chk("ext", {7'h00, mod_out}, {7'h00, i[0]});
      end
      wr(4'h5, 8'hff);
      rd(4'h5);
      chk("unm", v, 8'h00);
      rd(4'h0);
      chk("kept", v, 8'h88);
      // Carrier selects swapped; each carrier pin is followed in turn
      wr(4'h1, 8'h10);
      for (i = 0; i < 8; i++) begin
         wr(4'h0, {7'h40, i[2]});
         carrier_a <= i[0];
         carrier_b <= i[1];
         e = i[2] ? i[1] : i[0];
         repeat (6) @(posedge core_clk);
         #1;
         chk("car", {7'h00, mod_out}, {7'h00, e});
         rd(4'h0);
         chk("sel", v, {4'h8, e, 2'h0, i[2]});
      end
      final_report;
   end
endmodule
`default_nettype wire
